//--- core/tx_endpoint_ctrl.sv
// transmit endpoint lower control/status byte with apb access and interrupt
// assumes link events are single-cycle pulses on core_clk; host_role from link logic
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module tx_endpoint_ctrl
  import tx_ep_pkg::*;
#(
  parameter int buffers = 2
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        pkt_sent,
  input  wire logic        in_token,
  input  wire logic        stall_done,
  input  wire logic        no_handshake,
  input  wire logic        handshake_ok,
  input  wire logic        host_role_pin,
  output logic             answer_stall,
  output logic             fifo_flush,
  output logic             data_toggle_bit,
  output logic             irq
);
  logic        host_meta_reg;
  logic        host_role_reg;
  logic        tx_packet_ready;
  logic        error_reg;
  logic        setup_reg;
  logic        naktimeout_reg;
  logic        send_stall_reg;
  logic        stalled_reg;
  logic [3:0]  tx_interrupt_status_reg;
  logic [3:0]  irq_mask_reg;
  xfer_e       xfer_reg;
  logic        access;
  logic        wr;
  logic        rd;
  logic        wr_ctrl;
  logic        flush_req;
  logic        retry_fail;
  logic        limit_hit;
  logic        stall_event;
  logic        tx_fifo_nonempty;
  logic        fifo_full;
  logic [1:0]  pkt_count;
  logic        load_pulse;
  logic        drop_all;
  logic [3:0]  irq_events;
  logic [7:0]  ctrl_view;
  logic [31:0] rdata_next;

  assign access = psel && penable && pready;
  assign wr     = access && pwrite;
  assign rd     = access && !pwrite;
  assign wr_ctrl = wr && paddr == ctrl_low_addr;
  assign flush_req = wr_ctrl && pwdata[flush_pos];

  // host mode retry failure only counts in bulk or interrupt
  assign retry_fail = host_role_reg && (xfer_reg == xfer_bulk || xfer_reg == xfer_interrupt)
                      && limit_hit;
  assign stall_event = !host_role_reg && stall_done;
  assign load_pulse  = wr_ctrl && pwdata[tx_packet_ready_pos] && !pwdata[flush_pos];
  assign drop_all    = retry_fail || stall_event;

  // role pin crosses from outside
  always_ff @(posedge core_clk) begin
    if (rst) begin
      host_meta_reg <= 1'b0;
      host_role_reg <= 1'b0;
    end else begin
      host_meta_reg <= host_role_pin;
      host_role_reg <= host_meta_reg;
    end
  end

  tx_packet_count #(.buffers(buffers)) u_count (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (load_pulse),
    .sent     (pkt_sent),
    .drop_one (flush_req),
    .drop_all (drop_all),
    .nonempty (tx_fifo_nonempty),
    .full     (fifo_full),
    .count    (pkt_count)
  );

  tx_retry_count u_retry (
    .core_clk     (core_clk),
    .rst          (rst),
    .no_handshake (no_handshake && host_role_reg),
    .handshake    (handshake_ok),
    .clear        (drop_all || flush_req),
    .limit_hit    (limit_hit)
  );

  // packet-ready: set by software, cleared by link events
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_packet_ready <= 1'b0;
    end else if (flush_req || drop_all) begin
      tx_packet_ready <= 1'b0;
    end else if (load_pulse) begin
      // second buffer free: leave ready clear for next queueing
      tx_packet_ready <= (buffers == 1) || (pkt_count != 2'h0);
    end else if (pkt_sent) begin
      tx_packet_ready <= 1'b0;
    end else if (!fifo_full && pkt_count != 2'h0 && buffers == 2) begin
      tx_packet_ready <= 1'b0;
    end
  end

  // error flag, host role only, sticky until software clears
  always_ff @(posedge core_clk) begin
    if (rst) begin
      error_reg <= 1'b0;
    end else if (retry_fail) begin
      error_reg <= 1'b1;
    end else if (wr_ctrl && !pwdata[error_pos]) begin
      error_reg <= 1'b0;
    end
  end

  // role-dependent bits 4 and 7
  always_ff @(posedge core_clk) begin
    if (rst) begin
      send_stall_reg <= 1'b0;
      setup_reg      <= 1'b0;
      naktimeout_reg <= 1'b0;
    end else if (wr_ctrl) begin
      send_stall_reg <= !host_role_reg && pwdata[send_stall_pos];
      setup_reg      <= host_role_reg && pwdata[send_stall_pos];
      naktimeout_reg <= host_role_reg && naktimeout_reg && pwdata[reserved_pos];
    end
  end

  // stalled flag: set wins over software clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stalled_reg <= 1'b0;
    end else if (stall_event) begin
      stalled_reg <= 1'b1;
    end else if (wr_ctrl && !pwdata[stalled_pos]) begin
      stalled_reg <= 1'b0;
    end
  end

  // data toggle clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_toggle_bit <= 1'b0;
    end else if (wr_ctrl && pwdata[clear_toggle_pos]) begin
      data_toggle_bit <= 1'b0;
    end else if (pkt_sent) begin
      data_toggle_bit <= !data_toggle_bit;
    end
  end

  // stall answer to in tokens
  always_ff @(posedge core_clk) begin
    if (rst) begin
      answer_stall <= 1'b0;
      fifo_flush   <= 1'b0;
    end else begin
      answer_stall <= in_token && send_stall_reg && !host_role_reg
                      && xfer_reg != xfer_iso;
      fifo_flush   <= flush_req || drop_all;
    end
  end

  // interrupt status, mask and config registers
  assign irq_events = {stall_event, retry_fail, flush_req, pkt_sent};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_interrupt_status_reg <= irq_none;
    end else if (rd && paddr == irq_status_addr) begin
      tx_interrupt_status_reg <= irq_events;
    end else begin
      tx_interrupt_status_reg <= tx_interrupt_status_reg | irq_events;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_mask_reg <= irq_none;
      xfer_reg     <= xfer_bulk;
    end else if (wr && paddr == irq_mask_addr) begin
      irq_mask_reg <= pwdata[3:0];
    end else if (wr && paddr == role_addr) begin
      xfer_reg <= xfer_e'(pwdata[1:0]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(tx_interrupt_status_reg & irq_mask_reg);
    end
  end

  // read view of the control byte
  assign ctrl_view = {host_role_reg && naktimeout_reg, 1'b0,
                      host_role_reg ? 1'b0 : stalled_reg,
                      host_role_reg ? setup_reg : send_stall_reg,
                      1'b0, error_reg, tx_fifo_nonempty, tx_packet_ready};

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (paddr)
      ctrl_low_addr:   rdata_next = {24'h000000, ctrl_view};
      irq_status_addr: rdata_next = {28'h0000000, tx_interrupt_status_reg};
      irq_mask_addr:   rdata_next = {28'h0000000, irq_mask_reg};
      role_addr:       rdata_next = {30'h00000000, xfer_reg};
      toggle_addr:     rdata_next = {31'h00000000, data_toggle_bit};
      default:         rdata_next = 32'h0000_0000;
    endcase
  end

  // one wait cycle: pready rises in the second access cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= rdata_next;
      pslverr <= psel && penable && !pready &&
                 !(paddr == ctrl_low_addr || paddr == irq_status_addr ||
                   paddr == irq_mask_addr || paddr == role_addr || paddr == toggle_addr);
    end
  end
endmodule : tx_endpoint_ctrl
`default_nettype wire

//--- core/tx_ep_pkg.sv
// package for the transmit endpoint control/status block
// assumes a 32-bit apb slave with word-aligned registers
package tx_ep_pkg;
  localparam logic [11:0] ctrl_low_index     = 12'h112;
  localparam logic [11:0] ctrl_low_addr      = 12'h448;
  localparam logic [11:0] irq_status_addr    = 12'h500;
  localparam logic [11:0] irq_mask_addr      = 12'h504;
  localparam logic [11:0] role_addr          = 12'h508;
  localparam logic [11:0] toggle_addr        = 12'h50C;
  localparam int          tx_packet_ready_pos          = 0;
  localparam int          tx_fifo_nonempty_pos         = 1;
  localparam int          error_pos          = 2;
  localparam int          flush_pos          = 3;
  localparam int          send_stall_pos     = 4;
  localparam int          stalled_pos        = 5;
  localparam int          clear_toggle_pos   = 6;
  localparam int          reserved_pos       = 7;
  localparam logic [7:0]  ctrl_low_reset     = 8'h00;
  localparam logic [1:0]  retry_limit        = 2'h3;
  localparam logic [3:0]  irq_none           = 4'h0;
  localparam int          irq_tx_done        = 0;
  localparam int          irq_flush          = 1;
  localparam int          irq_error          = 2;
  localparam int          irq_stall_sent     = 3;
  typedef enum logic [1:0] {xfer_bulk, xfer_interrupt, xfer_iso, xfer_control} xfer_e;
endpackage : tx_ep_pkg

//--- core/tx_packet_count.sv
// counts packets held in the transmit fifo (one or two buffers)
// assumes load and send events arrive as single-cycle pulses
`timescale 1ns/1ns
`default_nettype none
module tx_packet_count
  import tx_ep_pkg::*;
#(
  parameter int buffers = 2
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic       sent,
  input  wire logic       drop_one,
  input  wire logic       drop_all,
  output logic            nonempty,
  output logic            full,
  output logic [1:0]      count
);
  initial begin
    if (buffers < 1 || buffers > 2) $error("buffers must be 1 or 2");
  end

  always_ff @(posedge core_clk) begin
    if (rst || drop_all) begin
      count <= 2'h0;
    end else if (load && !(sent || drop_one) && count < 2'(buffers)) begin
      count <= count + 2'h1;
    end else if (!load && (sent || drop_one) && count != 2'h0) begin
      count <= count - 2'h1;
    end
  end

  assign nonempty = (count != 2'h0);
  assign full     = (count == 2'(buffers));
endmodule : tx_packet_count
`default_nettype wire

//--- core/tx_retry_count.sv
// counts failed transmit attempts without handshake
// assumes attempt outcomes arrive as single-cycle pulses
`timescale 1ns/1ns
`default_nettype none
module tx_retry_count
  import tx_ep_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       no_handshake,
  input  wire logic       handshake,
  input  wire logic       clear,
  output logic            limit_hit
);
  logic [1:0] tries_reg;

  always_ff @(posedge core_clk) begin
    if (rst || clear || handshake) begin
      tries_reg <= 2'h0;
    end else if (no_handshake && tries_reg != retry_limit) begin
      tries_reg <= tries_reg + 2'h1;
    end
  end

  assign limit_hit = no_handshake && (tries_reg == retry_limit - 2'h1);
endmodule : tx_retry_count
`default_nettype wire

//--- sim/tx_ep_properties.sv
// port checker for the tx endpoint control block
// assumes it is bound to tx_endpoint_ctrl
`timescale 1ns/1ns
`default_nettype none
module tx_ep_properties
  import tx_ep_pkg::*;
#(
  parameter int buffers = 2
) (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pkt_sent,
  input wire logic        in_token,
  input wire logic        stall_done,
  input wire logic        no_handshake,
  input wire logic        handshake_ok,
  input wire logic        answer_stall,
  input wire logic        fifo_flush,
  input wire logic        data_toggle_bit,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic acc;
  logic wr_ctrl;
  logic ev;
  assign acc = psel && penable && pready;
  assign wr_ctrl = acc && pwrite && paddr == ctrl_low_addr;
  assign ev = pkt_sent || stall_done || no_handshake || (acc && pwrite);
  sequence s_misses; handshake_ok ##2 no_handshake [*3]; endsequence
  sequence s_flush_wr; wr_ctrl && pwdata[flush_pos]; endsequence
  sequence s_status_rd; acc && !pwrite && paddr == irq_status_addr && !ev; endsequence
  property p_stall_cause; answer_stall |-> $past(in_token); endproperty
  property p_flush_wr; s_flush_wr |-> ##[1:2] fifo_flush; endproperty
  property p_stall_flush; stall_done |-> ##[1:2] fifo_flush; endproperty
  property p_retry_flush; s_misses |-> ##[1:2] fifo_flush; endproperty
  property p_flush_cause; fifo_flush |-> $past(ev) || $past(ev, 2); endproperty
  property p_toggle_clr;
    wr_ctrl && pwdata[clear_toggle_pos] && !pkt_sent |=> !data_toggle_bit;
  endproperty
  property p_irq_clr; s_status_rd |-> ##[1:2] !irq; endproperty
  property p_irq_cause; $rose(irq) |-> $past(ev) || $past(ev, 2) || $past(ev, 3); endproperty
  a_stall_cause: assert property (p_stall_cause) else $error("stall without token");
  a_flush_wr: assert property (p_flush_wr) else $error("flush write lost");
  a_stall_flush: assert property (p_stall_flush) else $error("no flush on stall");
  a_retry_flush: assert property (p_retry_flush) else $error("no flush on misses");
  a_flush_cause: assert property (p_flush_cause) else $error("flush without cause");
  a_toggle_clr: assert property (p_toggle_clr) else $error("toggle not cleared");
  a_irq_clr: assert property (p_irq_clr) else $error("irq stuck after read");
  a_irq_cause: assert property (p_irq_cause) else $error("irq without event");
endmodule : tx_ep_properties
bind tx_endpoint_ctrl tx_ep_properties #(.buffers(buffers)) u_props (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pkt_sent(pkt_sent),
  .in_token(in_token), .stall_done(stall_done), .no_handshake(no_handshake),
  .handshake_ok(handshake_ok), .answer_stall(answer_stall), .fifo_flush(fifo_flush),
  .data_toggle_bit(data_toggle_bit), .irq(irq));
`default_nettype wire

//--- sim/tx_link_peer.sv
// usb peer model: link event pulses, answers stalls
// assumes the bench calls fire from its main thread
`timescale 1ns/1ns
`default_nettype none
module tx_link_peer (
  input  wire logic core_clk,
  input  wire logic answer_stall,
  output logic      pkt_sent,
  output logic      in_token,
  output logic      stall_done,
  output logic      no_handshake,
  output logic      handshake_ok
);
  logic [3:0] ev = 4'h0;
  logic [3:0] pipe = 4'h0;
  logic       slow = 1'b0;
  logic       stall_q = 1'b0;
  int         stalls = 0;
  assign {handshake_ok, no_handshake, in_token, pkt_sent} = ev;
  assign stall_done = stall_q;
  // stall handshake goes out promptly or four cycles late
  always @(posedge core_clk) begin
    pipe <= {pipe[2:0], answer_stall};
    stall_q <= slow ? pipe[3] : answer_stall;
    if (answer_stall === 1'b1) stalls <= stalls + 1;
  end
  task automatic fire(input logic [3:0] m, input int n);
    @(posedge core_clk);
    ev <= m;
    repeat (n) @(posedge core_clk);
    ev <= 4'h0;
  endtask : fire
endmodule : tx_link_peer
`default_nettype wire

//--- sim/usb_tx_endpoint_ctrl_status_tb.sv
// bench for the tx endpoint control/status block
// assumes the peer model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module usb_tx_endpoint_ctrl_status_tb
  import tx_ep_pkg::*;
;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, host_role_pin = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, err, pkt_sent, in_token, stall_done, no_handshake, handshake_ok;
  logic answer_stall, fifo_flush, data_toggle_bit, irq;
  int mismatches = 0, comparisons = 0;
  tx_endpoint_ctrl #(.buffers(2)) u_dut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pkt_sent(pkt_sent), .in_token(in_token),
    .stall_done(stall_done), .no_handshake(no_handshake), .handshake_ok(handshake_ok),
    .host_role_pin(host_role_pin), .answer_stall(answer_stall), .fifo_flush(fifo_flush),
    .data_toggle_bit(data_toggle_bit), .irq(irq));
  tx_link_peer u_peer (.core_clk(core_clk), .answer_stall(answer_stall),
    .pkt_sent(pkt_sent), .in_token(in_token), .stall_done(stall_done),
    .no_handshake(no_handshake), .handshake_ok(handshake_ok));
  initial forever #10 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rd
  task automatic s_reset;
    rd(ctrl_low_addr, {24'h0, ctrl_low_reset}, "ctrl reset");
    rd(12'h600, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, err});
  endtask : s_reset
  task automatic s_buffers;
    wr(irq_mask_addr, 32'hF);
    wr(ctrl_low_addr, 32'h1);
    rd(ctrl_low_addr, 32'h2, "one held");
    wr(ctrl_low_addr, 32'h1);
    rd(ctrl_low_addr, 32'h3, "two held");
    u_peer.fire(4'h1, 1);
    rd(ctrl_low_addr, 32'h2, "one sent");
    chk("irq", 32'h1, {31'h0, irq});
    rd(toggle_addr, 32'h1, "toggle");
    wr(ctrl_low_addr, 32'h40);
    rd(toggle_addr, 32'h0, "toggle clr");
    u_peer.fire(4'h1, 1);
    rd(ctrl_low_addr, 32'h0, "empty");
    rd(irq_status_addr, 32'h1, "sent irq");
    repeat (2) @(posedge core_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask : s_buffers
  task automatic s_flush;
    wr(ctrl_low_addr, 32'h1);
    wr(ctrl_low_addr, 32'h8);
    rd(ctrl_low_addr, 32'h0, "flushed");
    rd(irq_status_addr, 32'h2, "flush irq");
  endtask : s_flush
  task automatic s_stall;
    wr(ctrl_low_addr, 32'h10);
    u_peer.slow = 1'b1;
    u_peer.fire(4'h2, 1);
    repeat (8) @(posedge core_clk);
    chk("stalls", 32'h1, u_peer.stalls);
    rd(ctrl_low_addr, 32'h30, "stalled");
    rd(irq_status_addr, 32'h8, "stall irq");
    wr(ctrl_low_addr, 32'h0);
    rd(ctrl_low_addr, 32'h0, "unstalled");
    u_peer.fire(4'h2, 1);
    wr(role_addr, 32'h2);
    wr(ctrl_low_addr, 32'h10);
    u_peer.fire(4'h2, 1);
    repeat (4) @(posedge core_clk);
    chk("iso stalls", 32'h1, u_peer.stalls);
    wr(ctrl_low_addr, 32'h0);
    wr(role_addr, 32'h0);
  endtask : s_stall
  task automatic s_host;
    host_role_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    wr(ctrl_low_addr, 32'h1);
    u_peer.fire(4'h8, 1);
    u_peer.fire(4'h4, 3);
    rd(ctrl_low_addr, 32'h4, "error");
    rd(irq_status_addr, 32'h4, "error irq");
    wr(ctrl_low_addr, 32'h0);
    rd(ctrl_low_addr, 32'h0, "error clr");
    wr(ctrl_low_addr, 32'h10);
    u_peer.fire(4'h2, 1);
    repeat (4) @(posedge core_clk);
    chk("host stalls", 32'h1, u_peer.stalls);
  endtask : s_host
  task automatic tally_and_finish;
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    s_reset();
    s_buffers();
    s_flush();
    s_stall();
    s_host();
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end
endmodule : usb_tx_endpoint_ctrl_status_tb
`default_nettype wire
